// File: design/scr1_control_reg.sv
// First control register with shadow stage and update logic
//
// What this block does
// - Address space 0x00-0x16, holes at 0x05, 0x06.
// - Control register at 0x00, four bytes wide.
// - Shadowed fields move on update or profile change.
// - Bit 31 enables RAM, default off.
// - Bits 30:29 pick playback destination, default 00b.
// - Bit 23 enables keying pin, manual mode only.
// - Bit 22 turns on inverse sinc filter.
// - Bits 20:17 profile code, immediate, needs RAM.
// - Bit 16 selects sine, else cosine.
// - Bit 15 reloads ramp timer on update, only while ramp runs.
// - Bit 14 pulses ramp clear, sync-aligned.
// - Bit 12 holds ramp clear, sync-aligned.
// - Bit 13 clears phase accumulator on update.
// - Bit 11 holds phase accumulator in reset.
// - Bit 10 reloads amplitude ramp timer, auto keying.
// - Bit 9 enables output shift keying.
// - Bit 8 selects automatic keying when enabled.
// - Bit 7 stops digital core clocks, immediate.
`timescale 1ns/1ps
`default_nettype none
`include "scr1_defs.svh"

module scr1_control_reg #(
	parameter int ADDR_W = `SCR1_ADDR_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	input wire logic [ADDR_W-1:0] address,
	input wire logic [31:0] writeData,
	input wire logic updateStrobe,
	input wire logic [2:0] profilePins,
	input wire logic syncClkEdge,
	input wire logic keyPin,
	input wire logic rampEnable,
	output logic [31:0] readData,
	output logic readValid,
	output logic addrError,
	output scr1_pkg::scr1_ctrl_t ctrl,
	output scr1_pkg::scr1_pulse_t pulses,
	output logic keyPinGated
);

	import scr1_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	// Decode compares against five-bit addresses only
	if (ADDR_W != `SCR1_ADDR_W) begin : gBadAddrW
		$error("scr1_control_reg: ADDR_W must be 5");
	end

	// Last register address must fit the address width
	if (`SCR1_ADDR_LAST >= (1 << ADDR_W)) begin : gBadLast
		$error("scr1_control_reg: address map exceeds ADDR_W");
	end

	////////////////////////////////////////////////////////////////////////
	// Field decoding helpers

	// Keying mode pair {enable, auto} of a register word
	function automatic logic [1:0] keyModeOf(input logic [31:0] w);
		keyModeOf = {w[`SCR1_BIT_KEY_EN], w[`SCR1_BIT_KEY_AUTO]};
	endfunction

	// True when the word selects the given keying mode
	function automatic logic keyModeIs(input logic [31:0] w,
		input logic [1:0] m);
		keyModeIs = (keyModeOf(w) == m);
	endfunction

	// Profile code field of a register word
	function automatic logic [3:0] profileOf(input logic [31:0] w);
		profileOf = w[`SCR1_BIT_PROF_HI:`SCR1_BIT_PROF_LO];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Address decode

	// Valid register address within the map
	function automatic logic addrValid(input logic [ADDR_W-1:0] a);
		addrValid = (a <= `SCR1_ADDR_LAST) && (a != `SCR1_ADDR_HOLE_A)
			&& (a != `SCR1_ADDR_HOLE_B);
	endfunction

	logic hitCtrl;
	assign hitCtrl = (address == `SCR1_CTRL1_ADDR);

	////////////////////////////////////////////////////////////////////////
	// Shadow and active stages

	logic [31:0] shadow_ff;
	logic [31:0] active_ff;
	logic [2:0] profPrev_ff;
	logic updateEvent;
	logic [31:0] nxt_shadow;

	// Profile change counts as an update event
	assign updateEvent = updateStrobe | (profilePins != profPrev_ff);
	assign nxt_shadow = writeData & `SCR1_WRITE_MASK;

	// Host writes land in shadow
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			shadow_ff <= `SCR1_CTRL1_RESET;
		else if (writeStrobe && hitCtrl)
			shadow_ff <= nxt_shadow;
	end

	// Track profile pins to spot a change
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			profPrev_ff <= 3'h0;
		else
			profPrev_ff <= profilePins;
	end

	// Transfer shadow on update event
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			active_ff <= `SCR1_CTRL1_RESET;
		else if (updateEvent)
			active_ff <= shadow_ff;
	end

	////////////////////////////////////////////////////////////////////////
	// Readback

	// Reads return shadow contents; other addresses read zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			readData <= 32'h0000_0000;
			readValid <= 1'b0;
			addrError <= 1'b0;
		end else begin
			readValid <= readStrobe;
			addrError <= (readStrobe | writeStrobe) & ~addrValid(address);
			if (readStrobe && hitCtrl)
				readData <= shadow_ff;
			else if (readStrobe)
				readData <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Effective control outputs

	// Effective control flops, one per field
	logic ramEnable_ff;
	logic [1:0] playbackDest_ff;
	logic keyPinEnable_ff;
	logic inverseSincOn_ff;
	logic [3:0] profileCode_ff;
	logic sineSelect_ff;
	logic phaseHold_ff;
	logic rampHoldAct_ff;
	logic [1:0] keyMode_ff;
	logic keyingEnabled_ff;
	logic powerDown_ff;

	// RAM enable from the active stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ramEnable_ff <= '0;
		else
			ramEnable_ff <= active_ff[`SCR1_BIT_RAM_EN];
	end

	// Playback destination from the active stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			playbackDest_ff <= '0;
		else
			playbackDest_ff <= active_ff[`SCR1_BIT_PLAY_HI:
				`SCR1_BIT_PLAY_LO];
	end

	// Keying pin enable, manual mode only
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			keyPinEnable_ff <= '0;
		else
			keyPinEnable_ff <= active_ff[`SCR1_BIT_KEY_PIN]
				&& keyModeIs(active_ff, `SCR1_KEY_MANUAL);
	end

	// Inverse sinc filter switch
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			inverseSincOn_ff <= '0;
		else
			inverseSincOn_ff <= active_ff[`SCR1_BIT_INV_SINC];
	end

	// Profile code acts at once, gated by active RAM enable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			profileCode_ff <= '0;
		else if (active_ff[`SCR1_BIT_RAM_EN])
			profileCode_ff <= profileOf(shadow_ff);
		else
			profileCode_ff <= '0;
	end

	// Sine or cosine output choice
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			sineSelect_ff <= '0;
		else
			sineSelect_ff <= active_ff[`SCR1_BIT_SINE];
	end

	// Static phase accumulator clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			phaseHold_ff <= '0;
		else
			phaseHold_ff <= active_ff[`SCR1_BIT_PHASE_CLR];
	end

	// Keying enable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			keyingEnabled_ff <= '0;
		else
			keyingEnabled_ff <= active_ff[`SCR1_BIT_KEY_EN];
	end

	// Keying mode, zero while keying is off
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			keyMode_ff <= '0;
		else if (active_ff[`SCR1_BIT_KEY_EN])
			keyMode_ff <= keyModeOf(active_ff);
		else
			keyMode_ff <= '0;
	end

	// Power-down acts at once from the shadow stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			powerDown_ff <= '0;
		else
			powerDown_ff <= shadow_ff[`SCR1_BIT_PWR_DOWN];
	end

	// Pack the flops into the control word
	assign ctrl = {ramEnable_ff, playbackDest_ff, keyPinEnable_ff,
		inverseSincOn_ff, profileCode_ff, sineSelect_ff, phaseHold_ff,
		rampHoldAct_ff, keyMode_ff, keyingEnabled_ff,
		powerDown_ff};

	// Manual keying pin passes only when enabled
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			keyPinGated <= 1'b0;
		else
			keyPinGated <= keyPin & active_ff[`SCR1_BIT_KEY_PIN]
				& keyModeIs(active_ff, `SCR1_KEY_MANUAL);
	end

	////////////////////////////////////////////////////////////////////////
	// Ramp clear alignment to port-synchronous clock

	logic rampLoadFire;
	logic rampHoldReq;
	logic rampPulseReq;
	logic rampPulseFire;
	logic updPrev_ff;
	logic updSeen;

	assign updSeen = updPrev_ff;

	// Delay event so active stage already holds new bits
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			updPrev_ff <= 1'b0;
		else
			updPrev_ff <= updateEvent;
	end

	assign rampHoldReq = updSeen;
	assign rampPulseReq = updSeen & active_ff[`SCR1_BIT_RAMP_AUTOCLR];

	scr1_sync_align uHoldAlign (
		.clk(clk),
		.rstn(rstn),
		.syncEdge(syncClkEdge),
		.request(rampHoldReq),
		.fire(rampLoadFire)
	);

	scr1_sync_align uPulseAlign (
		.clk(clk),
		.rstn(rstn),
		.syncEdge(syncClkEdge),
		.request(rampPulseReq),
		.fire(rampPulseFire)
	);

	// Static ramp clear follows bit on aligned edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rampHoldAct_ff <= 1'b0;
		else if (rampLoadFire)
			rampHoldAct_ff <= active_ff[`SCR1_BIT_RAMP_CLR];
	end

	////////////////////////////////////////////////////////////////////////
	// Update-driven pulses

	logic timerReload_ff;
	logic ampReload_ff;
	logic phaseClear_ff;
	logic rampClear_ff;

	// Ramp timer reload, only while the ramp runs
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			timerReload_ff <= '0;
		else
			timerReload_ff <= updSeen & rampEnable
				& active_ff[`SCR1_BIT_RAMP_RELOAD];
	end

	// Amplitude ramp reload, automatic keying only
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ampReload_ff <= '0;
		else
			ampReload_ff <= updSeen & active_ff[`SCR1_BIT_AMP_RELOAD]
				& keyModeIs(active_ff, `SCR1_KEY_AUTO);
	end

	// Phase accumulator autoclear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			phaseClear_ff <= '0;
		else
			phaseClear_ff <= updSeen
				& active_ff[`SCR1_BIT_PHASE_AUTOCLR];
	end

	// Ramp autoclear, already aligned to the sync edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rampClear_ff <= '0;
		else
			rampClear_ff <= rampPulseFire;
	end

	// Pack the pulse flops
	assign pulses = {timerReload_ff, ampReload_ff, phaseClear_ff,
		rampClear_ff};

endmodule

`default_nettype wire

// File: design/scr1_defs.svh
// Constants for the first control register block
`ifndef SCR1_DEFS_SVH
`define SCR1_DEFS_SVH

`define SCR1_ADDR_W 5
`define SCR1_ADDR_LAST 5'h16
`define SCR1_ADDR_HOLE_A 5'h05
`define SCR1_ADDR_HOLE_B 5'h06
`define SCR1_CTRL1_ADDR 5'h00
`define SCR1_CTRL1_BYTES 3'h4
`define SCR1_CTRL1_RESET 32'h0000_0000
`define SCR1_WRITE_MASK 32'hE0DF_FF80
`define SCR1_BIT_RAM_EN 31
`define SCR1_BIT_PLAY_HI 30
`define SCR1_BIT_PLAY_LO 29
`define SCR1_BIT_KEY_PIN 23
`define SCR1_BIT_INV_SINC 22
`define SCR1_BIT_PROF_HI 20
`define SCR1_BIT_PROF_LO 17
`define SCR1_BIT_SINE 16
`define SCR1_BIT_RAMP_RELOAD 15
`define SCR1_BIT_RAMP_AUTOCLR 14
`define SCR1_BIT_PHASE_AUTOCLR 13
`define SCR1_BIT_RAMP_CLR 12
`define SCR1_BIT_PHASE_CLR 11
`define SCR1_BIT_AMP_RELOAD 10
`define SCR1_BIT_KEY_EN 9
`define SCR1_BIT_KEY_AUTO 8
`define SCR1_BIT_PWR_DOWN 7
`define SCR1_KEY_MANUAL 2'h2
`define SCR1_KEY_AUTO 2'h3

`endif

// File: design/scr1_pkg.sv
// Types shared by the first control register block
package scr1_pkg;

	// Effective controls seen by the synthesis logic
	typedef struct packed {
		logic ramEnable;
		logic [1:0] playbackDest;
		logic keyPinEnable;
		logic inverseSincOn;
		logic [3:0] profileCode;
		logic sineSelect;
		logic phaseHold;
		logic rampHold;
		logic [1:0] keyMode;
		logic keyingEnabled;
		logic digitalPowerDown;
	} scr1_ctrl_t;

	// One-cycle pulses derived from an update event
	typedef struct packed {
		logic rampTimerReload;
		logic amplitudeRampReload;
		logic phaseClear;
		logic rampClear;
	} scr1_pulse_t;

endpackage

// File: design/scr1_sync_align.sv
// Aligns a request to the next port-synchronous clock edge
`timescale 1ns/1ps
`default_nettype none

module scr1_sync_align (
	input wire logic clk,
	input wire logic rstn,
	input wire logic syncEdge,
	input wire logic request,
	output logic fire
);

	logic pend_ff;

	// Hold request until the next edge, then pulse once
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pend_ff <= 1'b0;
			fire <= 1'b0;
		end else begin
			fire <= syncEdge & (pend_ff | request);
			if (syncEdge)
				pend_ff <= 1'b0;
			else if (request)
				pend_ff <= 1'b1;
		end
	end

endmodule

`default_nettype wire

// File: sim/scr1_host.sv
// Host model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module scr1_host (
	input wire logic clk,
	output logic wr,
	output logic rd,
	output logic [4:0] addr,
	output logic [31:0] data
);
	// Idle bus at start
	initial begin
		wr = 1'b0;
		rd = 1'b0;
		addr = 5'h00;
		data = 32'h0;
	end
	// One access, held over one rising edge
	task automatic acc(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		@(negedge clk);
		wr = w;
		rd = !w;
		addr = a;
		data = d; // Whole word
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
		data = ~d; // Stale data never repeats
	endtask
endmodule
`default_nettype wire

// File: sim/scr1_control_monitor.sv
// Port assertions for the control register
`timescale 1ns/1ps
`default_nettype none
module scr1_control_monitor
	import scr1_pkg::*;
#(
	parameter int ADDR_W = 5
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	input wire logic [ADDR_W-1:0] address,
	input wire logic [31:0] writeData,
	input wire logic updateStrobe,
	input wire logic [2:0] profilePins,
	input wire logic syncClkEdge,
	input wire logic [31:0] readData,
	input wire logic readValid,
	input wire logic addrError,
	input wire scr1_pkg::scr1_ctrl_t ctrl,
	input wire scr1_pkg::scr1_pulse_t pulses
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Access answers
	property p_rd; readStrobe |=> readValid; endproperty
	a_rd: assert property (p_rd) else $error("no read answer");
	property p_hole; writeStrobe && (address == 5'h05 || address == 5'h06
		|| address > 5'h16) |=> addrError; endproperty
	a_hole: assert property (p_hole) else $error("no addr error");
	property p_open; readValid |-> readData[28:24] == 5'h00
		&& !readData[21]; endproperty
	a_open: assert property (p_open) else $error("open bits");
	// Effective controls
	property p_prof; ctrl.profileCode != 4'h0 |-> ctrl.ramEnable; endproperty
	a_prof: assert property (p_prof) else $error("profile gate");
	property p_arr; pulses.amplitudeRampReload |-> ctrl.keyMode == 2'h3;
	endproperty
	a_arr: assert property (p_arr) else $error("amp reload");
	property p_rclr; pulses.rampClear |-> $past(syncClkEdge, 2); endproperty
	a_rclr: assert property (p_rclr) else $error("ramp clear");
	property p_pwr; writeStrobe && address == 5'h00 && writeData[7]
		|-> ##[1:2] ctrl.digitalPowerDown; endproperty
	a_pwr: assert property (p_pwr) else $error("power down");
	property p_shd; (!updateStrobe && $stable(profilePins)) [*3]
		|=> $stable(ctrl.sineSelect); endproperty
	a_shd: assert property (p_shd) else $error("shadow leak");
	c_phase: cover property (pulses.phaseClear);
	c_ramp: cover property (pulses.rampClear);
	c_hole: cover property (addrError);
endmodule
bind scr1_control_reg scr1_control_monitor #(.ADDR_W(ADDR_W)) u_mon (
	.clk, .rstn, .writeStrobe, .readStrobe, .address, .writeData,
	.updateStrobe, .profilePins, .syncClkEdge, .readData, .readValid,
	.addrError, .ctrl, .pulses);
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the control register
`timescale 1ns/1ps
`default_nettype none
module tb;
	import scr1_pkg::*;
	logic clk, rstn, wr, rd, upd, syncEdge, keyPin, rdValid, addrErr, keyGate;
	logic [4:0] addr;
	logic [31:0] wdata, rdata, shadow, active, rnd;
	logic [2:0] prof;
	logic rampEn;
	int seen[4], want[4];
	scr1_ctrl_t ctrl;
	scr1_pulse_t pulses;
	int n_errors, n_checks, cyc;
	scr1_control_reg u_scr1_control_reg (.clk(clk), .rstn(rstn),
		.writeStrobe(wr), .readStrobe(rd), .address(addr), .writeData(wdata),
		.updateStrobe(upd), .profilePins(prof), .syncClkEdge(syncEdge),
		.keyPin(keyPin), .rampEnable(rampEn), .readData(rdata),
		.readValid(rdValid), .addrError(addrErr), .ctrl(ctrl),
		.pulses(pulses), .keyPinGated(keyGate));
	scr1_host u_scr1_host (.clk(clk), .wr(wr), .rd(rd), .addr(addr),
		.data(wdata));
	////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Port-sync pulse every fourth cycle, and run limit
	always @(negedge clk) begin
		cyc <= cyc + 1;
		syncEdge <= (cyc % 4 == 3);
		for (int i = 0; i < 4; i++) seen[i] += pulses[i];
		if (cyc == 3000) begin
			n_errors++;
			finish_test();
		end
	end
	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic wr32(input logic [4:0] a, input logic [31:0] d);
		u_scr1_host.acc(1'b1, a, d);
		if (a == 5'h00) shadow = d & 32'hE0DF_FF80;
		chk("addrError", a == 5'h05 || a == 5'h06 || a > 5'h16, addrErr);
	endtask
	task automatic rd32();
		u_scr1_host.acc(1'b0, 5'h00, 32'h0);
		chk("readData", shadow, rdata);
		chk("readValid", 1, rdValid);
	endtask
	task automatic applied();
		active = shadow;
		want[3] += active[15] & rampEn;
		want[2] += active[10] && active[9:8] == 2'h3;
		want[1] += active[13];
		want[0] += active[14];
	endtask
	task automatic update();
		@(negedge clk);
		upd = 1'b1;
		@(negedge clk);
		upd = 1'b0;
		applied();
		repeat (7) @(negedge clk);
	endtask
	task automatic ctrlChk();
		chk("ctrl", {21'h0, active[31:29], active[22], active[16],
			active[11], active[12], active[9],
			active[9] ? active[9:8] : 2'h0,
			active[23] && active[9:8] == 2'h2},
			{21'h0, ctrl.ramEnable, ctrl.playbackDest, ctrl.inverseSincOn,
			ctrl.sineSelect, ctrl.phaseHold, ctrl.rampHold,
			ctrl.keyingEnabled, ctrl.keyMode, ctrl.keyPinEnable});
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rstn, upd, keyPin, cyc, n_errors, n_checks} = '0;
		{prof, shadow, active, syncEdge, rampEn} = '0;
		seen = '{default: 0};
		want = '{default: 0};
		rnd = 32'h2221;
		repeat (4) @(posedge clk);
		@(negedge clk) rstn = 1'b1;
		rd32();
		ctrlChk();
		repeat (12) begin
			rnd = nextRand(rnd);
			wr32(5'h00, rnd);
			ctrlChk();
			rd32();
			rampEn = rnd[3];
			update();
			ctrlChk();
		end
		$display("random words done");
		wr32(5'h01, 32'h1);
		wr32(5'h05, 32'hFFFF_FFFF);
		wr32(5'h06, 32'hFFFF_FFFF);
		wr32(5'h17, 32'hFFFF_FFFF);
		rd32();
		wr32(5'h00, 32'h0000_0080);
		@(negedge clk);
		chk("powerDown", 1, ctrl.digitalPowerDown);
		$display("map and power-down done");
		wr32(5'h00, 32'h801E_0000);
		update();
		wr32(5'h00, 32'h8006_0000);
		@(negedge clk);
		chk("profile", 3, ctrl.profileCode);
		wr32(5'h00, 32'h001E_0000);
		update();
		chk("profile", 0, ctrl.profileCode);
		$display("profile done");
		keyPin = 1'b1;
		wr32(5'h00, 32'h0080_0200);
		update();
		chk("keyGate", 1, keyGate);
		wr32(5'h00, 32'h0080_E700);
		update();
		chk("keyGate", 0, keyGate);
		wr32(5'h00, 32'h0001_5A00);
		prof = 3'h5;
		applied();
		repeat (7) @(negedge clk);
		ctrlChk();
		repeat (8) @(negedge clk);
		chk("rampTimerReload", want[3], seen[3]);
		chk("amplitudeRampReload", want[2], seen[2]);
		chk("phaseClear", want[1], seen[1]);
		chk("rampClear", want[0], seen[0]);
		$display("keying and clears done");
		finish_test();
	end
endmodule
`default_nettype wire
